// >>> verilog/simd_alu_pkg.sv
// constants, types and lane arithmetic for the packed add/subtract/test slice
// assumes: 32-bit operands, one register-bus word per register
package simd_alu_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 6;

    // register byte offsets
    localparam logic [5:0] OFS_OPERAND_A = 6'h00;
    localparam logic [5:0] OFS_OPERAND_B = 6'h04;
    localparam logic [5:0] OFS_COMMAND = 6'h08;
    localparam logic [5:0] OFS_RESULT = 6'h0C;
    localparam logic [5:0] OFS_FLAGS = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h14;

    // field layout
    localparam int unsigned FLAGS_POS = 28;
    localparam logic [31:0] CMD_MASK = 32'h000FFF3F;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [3:0] RESET_FLAGS = 4'h0;
    localparam logic [3:0] REG_STACK = 4'hD;
    localparam logic [3:0] REG_PC = 4'hF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        OP_SIGNED_HALVING_ADD_SUB_EXCHANGE = 4'h0,
        OP_SIGNED_HALVING_SUB_ADD_EXCHANGE = 4'h1,
        OP_SIGNED_HALVING_SUB_HALFWORDS = 4'h2,
        OP_SIGNED_HALVING_SUB_BYTES = 4'h3,
        OP_SIGNED_PACKED_SUB_HALFWORDS = 4'h4,
        OP_SIGNED_PACKED_SUB_BYTES = 4'h5,
        OP_SIGNED_ADD_SUB_EXCHANGE = 4'h6,
        OP_SIGNED_SUB_ADD_EXCHANGE = 4'h7,
        OP_BIT_TEST_AND = 4'h8,
        OP_EQUIVALENCE_TEST_XOR = 4'h9,
        OP_UNSIGNED_PACKED_ADD_HALFWORDS = 4'hA,
        OP_UNSIGNED_PACKED_ADD_BYTES = 4'hB
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_s;

    typedef struct packed {
        logic [11:0] rsvd_hi;
        logic [3:0] rm;
        logic [3:0] rn;
        logic [3:0] rd;
        logic [1:0] rsvd_lo;
        logic carry_in;
        logic carry_ok;
        logic [3:0] op;
    } cmd_s;

    typedef struct packed {
        logic [26:0] rsvd;
        logic bad_reg;
        logic bad_op;
        logic wrote;
        logic done;
        logic busy;
    } status_s;

    function automatic logic [15:0] halve16(logic [15:0] a, logic [15:0] b, logic sub);
        logic [16:0] s;
        s = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
        return s[16:1];
    endfunction

    function automatic logic [7:0] halve8(logic [7:0] a, logic [7:0] b, logic sub);
        logic [8:0] s;
        s = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
        return s[8:1];
    endfunction

    function automatic logic is_test(logic [3:0] op);
        return op == OP_BIT_TEST_AND || op == OP_EQUIVALENCE_TEST_XOR;
    endfunction

    function automatic logic op_known(logic [3:0] op);
        return op <= OP_UNSIGNED_PACKED_ADD_BYTES;
    endfunction

    function automatic logic [31:0] alu_result(logic [3:0] op, logic [31:0] a,
                                               logic [31:0] b);
        logic [31:0] r;
        r = RESET_WORD;
        case (op)
            OP_SIGNED_HALVING_ADD_SUB_EXCHANGE:
                r = {halve16(a[31:16], b[15:0], 1'b0), halve16(a[15:0], b[31:16], 1'b1)};
            OP_SIGNED_HALVING_SUB_ADD_EXCHANGE:
                r = {halve16(a[31:16], b[15:0], 1'b1), halve16(a[15:0], b[31:16], 1'b0)};
            OP_SIGNED_HALVING_SUB_HALFWORDS:
                r = {halve16(a[31:16], b[31:16], 1'b1), halve16(a[15:0], b[15:0], 1'b1)};
            OP_SIGNED_HALVING_SUB_BYTES:
                for (int i = 0; i < 4; i++) r[8*i +: 8] = halve8(a[8*i +: 8], b[8*i +: 8], 1'b1);
            OP_SIGNED_PACKED_SUB_HALFWORDS:
                r = {a[31:16] - b[31:16], a[15:0] - b[15:0]};
            OP_SIGNED_PACKED_SUB_BYTES:
                for (int i = 0; i < 4; i++) r[8*i +: 8] = a[8*i +: 8] - b[8*i +: 8];
            OP_SIGNED_ADD_SUB_EXCHANGE:
                r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
            OP_SIGNED_SUB_ADD_EXCHANGE:
                r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
            OP_BIT_TEST_AND:
                r = a & b;
            OP_EQUIVALENCE_TEST_XOR:
                r = a ^ b;
            OP_UNSIGNED_PACKED_ADD_HALFWORDS:
                r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
            OP_UNSIGNED_PACKED_ADD_BYTES:
                for (int i = 0; i < 4; i++) r[8*i +: 8] = a[8*i +: 8] + b[8*i +: 8];
            default:
                r = RESET_WORD;
        endcase
        return r;
    endfunction

endpackage

// >>> verilog/packed_simd_alu.sv
// packed add/subtract/test execution slice behind an AXI4-Lite register file
// assumes: single clock CLK, async active-low NRST, AXI4-Lite master on same clock
`timescale 1ns/1ps
`default_nettype none

module packed_simd_alu (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [simd_alu_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [simd_alu_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic WB_VALID,
    output logic [3:0] WB_INDEX,
    output logic [31:0] WB_DATA,
    output logic [3:0] FLAGS_NZCV
);

    // bus-side state
    logic aw_held_r, aw_held_nxt;
    logic w_held_r, w_held_nxt;
    logic [5:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // execution state
    simd_alu_pkg::state_e state_r, state_nxt;
    logic [31:0] opa_r, opa_nxt;
    logic [31:0] opb_r, opb_nxt;
    simd_alu_pkg::cmd_s cmd_r, cmd_nxt;
    logic [31:0] result_r, result_nxt;
    simd_alu_pkg::flags_s flags_r, flags_nxt;
    simd_alu_pkg::status_s status_r, status_nxt;
    logic wb_valid_r, wb_valid_nxt;
    logic [3:0] wb_index_r, wb_index_nxt;
    logic [31:0] wb_data_r, wb_data_nxt;

    logic do_write;
    logic do_read;
    logic launch;
    logic exec;
    logic [31:0] alu_res;
    logic test_op;
    logic reg_bad;
    logic op_ok;

    function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] nw,
                                               logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic addr_mapped(logic [5:0] a);
        return a == simd_alu_pkg::OFS_OPERAND_A || a == simd_alu_pkg::OFS_OPERAND_B ||
               a == simd_alu_pkg::OFS_COMMAND || a == simd_alu_pkg::OFS_RESULT ||
               a == simd_alu_pkg::OFS_FLAGS || a == simd_alu_pkg::OFS_STATUS;
    endfunction

    // no new address or data while a response waits: one write at a time
    assign AWREADY = !aw_held_r && !bvalid_r;
    assign WREADY = !w_held_r && !bvalid_r;
    assign ARREADY = !rvalid_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    assign RVALID = rvalid_r;
    assign RRESP = rresp_r;
    assign RDATA = rdata_r;
    assign WB_VALID = wb_valid_r;
    assign WB_INDEX = wb_index_r;
    assign WB_DATA = wb_data_r;
    assign FLAGS_NZCV = flags_r;

    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign do_read = ARVALID && !rvalid_r;
    assign launch = do_write && aw_addr_r == simd_alu_pkg::OFS_COMMAND;
    assign exec = state_r == simd_alu_pkg::ST_EXEC;
    assign alu_res = simd_alu_pkg::alu_result(cmd_r.op, opa_r, opb_r);
    assign test_op = simd_alu_pkg::is_test(cmd_r.op);

    // tests name only the first register; the rest name all three
    always_comb begin
        reg_bad = cmd_r.rn == simd_alu_pkg::REG_STACK || cmd_r.rn == simd_alu_pkg::REG_PC;
        if (!test_op) begin
            reg_bad = reg_bad ||
                      cmd_r.rd == simd_alu_pkg::REG_STACK || cmd_r.rd == simd_alu_pkg::REG_PC ||
                      cmd_r.rm == simd_alu_pkg::REG_STACK || cmd_r.rm == simd_alu_pkg::REG_PC;
        end
        op_ok = simd_alu_pkg::op_known(cmd_r.op) && !reg_bad;
    end

    // bus channel next values
    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (AWVALID && AWREADY) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = {AWADDR[5:2], 2'b00};
        end
        if (WVALID && WREADY) begin
            w_held_nxt = 1'b1;
            w_data_nxt = WDATA;
            w_strb_nxt = WSTRB;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_mapped(aw_addr_r) ? simd_alu_pkg::RESP_OKAY
                                               : simd_alu_pkg::RESP_SLVERR;
        end else if (bvalid_r && BREADY) begin
            bvalid_nxt = 1'b0;
        end
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = simd_alu_pkg::RESP_OKAY;
            case ({ARADDR[5:2], 2'b00})
                simd_alu_pkg::OFS_OPERAND_A: rdata_nxt = opa_r;
                simd_alu_pkg::OFS_OPERAND_B: rdata_nxt = opb_r;
                simd_alu_pkg::OFS_COMMAND: rdata_nxt = cmd_r;
                simd_alu_pkg::OFS_RESULT: rdata_nxt = result_r;
                simd_alu_pkg::OFS_FLAGS: rdata_nxt = {flags_r, 28'h0000000};
                simd_alu_pkg::OFS_STATUS: rdata_nxt = status_r;
                default: begin
                    rdata_nxt = simd_alu_pkg::RESET_WORD;
                    rresp_nxt = simd_alu_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && RREADY) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 6'h00;
            w_held_r <= 1'b0;
            w_data_r <= simd_alu_pkg::RESET_WORD;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= simd_alu_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= simd_alu_pkg::RESP_OKAY;
            rdata_r <= simd_alu_pkg::RESET_WORD;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // register file and execution; a command write starts one execute cycle.
    // exec never meets a bus write: the write response blocks the next one
    always_comb begin
        state_nxt = state_r;
        opa_nxt = opa_r;
        opb_nxt = opb_r;
        cmd_nxt = cmd_r;
        result_nxt = result_r;
        flags_nxt = flags_r;
        status_nxt = status_r;
        wb_valid_nxt = 1'b0;
        wb_index_nxt = wb_index_r;
        wb_data_nxt = wb_data_r;
        status_nxt.busy = 1'b0;
        if (do_write) begin
            case (aw_addr_r)
                simd_alu_pkg::OFS_OPERAND_A: opa_nxt = apply_strb(opa_r, w_data_r, w_strb_r);
                simd_alu_pkg::OFS_OPERAND_B: opb_nxt = apply_strb(opb_r, w_data_r, w_strb_r);
                simd_alu_pkg::OFS_COMMAND:
                    cmd_nxt = apply_strb(cmd_r, w_data_r, w_strb_r) & simd_alu_pkg::CMD_MASK;
                simd_alu_pkg::OFS_FLAGS:
                    if (w_strb_r[3]) begin
                        flags_nxt = w_data_r[simd_alu_pkg::FLAGS_POS +: 4];
                    end
                default: ;
            endcase
        end
        case (state_r)
            simd_alu_pkg::ST_IDLE: begin
                if (launch) begin
                    state_nxt = simd_alu_pkg::ST_EXEC;
                    status_nxt.busy = 1'b1;
                    status_nxt.done = 1'b0;
                    status_nxt.wrote = 1'b0;
                    status_nxt.bad_op = 1'b0;
                    status_nxt.bad_reg = 1'b0;
                end
            end
            simd_alu_pkg::ST_EXEC: begin
                state_nxt = simd_alu_pkg::ST_IDLE;
                status_nxt.done = 1'b1;
                status_nxt.bad_op = !simd_alu_pkg::op_known(cmd_r.op);
                status_nxt.bad_reg = reg_bad;
                if (op_ok) begin
                    result_nxt = alu_res;
                    if (test_op) begin
                        // flags only; no register written, V kept
                        flags_nxt.n = alu_res[31];
                        flags_nxt.z = alu_res == simd_alu_pkg::RESET_WORD;
                        flags_nxt.c = cmd_r.carry_ok ? cmd_r.carry_in : flags_r.c;
                        flags_nxt.v = flags_r.v;
                    end else begin
                        // packed lanes leave the flags as they were
                        flags_nxt = flags_r;
                        wb_valid_nxt = 1'b1;
                        wb_index_nxt = cmd_r.rd;
                        wb_data_nxt = alu_res;
                        status_nxt.wrote = 1'b1;
                    end
                end
            end
            default: state_nxt = simd_alu_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= simd_alu_pkg::ST_IDLE;
            opa_r <= simd_alu_pkg::RESET_WORD;
            opb_r <= simd_alu_pkg::RESET_WORD;
            cmd_r <= simd_alu_pkg::RESET_WORD;
            result_r <= simd_alu_pkg::RESET_WORD;
            flags_r <= simd_alu_pkg::RESET_FLAGS;
            status_r <= simd_alu_pkg::RESET_WORD;
            wb_valid_r <= 1'b0;
            wb_index_r <= 4'h0;
            wb_data_r <= simd_alu_pkg::RESET_WORD;
        end else begin
            state_r <= state_nxt;
            opa_r <= opa_nxt;
            opb_r <= opb_nxt;
            cmd_r <= cmd_nxt;
            result_r <= result_nxt;
            flags_r <= flags_nxt;
            status_r <= status_nxt;
            wb_valid_r <= wb_valid_nxt;
            wb_index_r <= wb_index_nxt;
            wb_data_r <= wb_data_nxt;
        end
    end

    a_exec_one_cycle: assert property (@(posedge CLK) disable iff (!NRST)
        launch && state_r == simd_alu_pkg::ST_IDLE |=> exec ##1 !exec && status_r.done)
        else $error("execute did not take exactly one cycle");

    a_test_no_write: assert property (@(posedge CLK) disable iff (!NRST)
        exec && test_op |=> !WB_VALID && !status_r.wrote)
        else $error("test operation wrote a register");

    a_test_nz_flags: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_EQUIVALENCE_TEST_XOR |=>
        FLAGS_NZCV[3] == ($past(opa_r[31]) ^ $past(opb_r[31])) &&
        FLAGS_NZCV[2] == ($past(opa_r) == $past(opb_r)))
        else $error("equivalence test gave wrong N or Z");

    a_test_carry_v: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && test_op |=>
        FLAGS_NZCV[0] == $past(flags_r.v) &&
        FLAGS_NZCV[1] == ($past(cmd_r.carry_ok) ? $past(cmd_r.carry_in) : $past(flags_r.c)))
        else $error("test handled C or V wrongly");

    a_lane_flags_kept: assert property (@(posedge CLK) disable iff (!NRST)
        exec && !test_op |=> $stable(FLAGS_NZCV))
        else $error("packed operation changed the flags");

    a_halving_sub_lanes: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_HALVING_SUB_HALFWORDS |=>
        WB_VALID && $signed(WB_DATA[31:16]) ==
        17'($signed({$past(opa_r[31]), $past(opa_r[31:16])}) -
            $signed({$past(opb_r[31]), $past(opb_r[31:16])})) >>> 1)
        else $error("halving halfword subtract top lane wrong");

    a_hx_top_lane: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_HALVING_ADD_SUB_EXCHANGE |=>
        WB_DATA[31:16] == 16'(({$past(opa_r[31]), $past(opa_r[31:16])} +
                               {$past(opb_r[15]), $past(opb_r[15:0])}) >> 1))
        else $error("halving exchange top lane wrong");

    a_ubyte_add_lanes: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_UNSIGNED_PACKED_ADD_BYTES |=>
        WB_DATA[7:0] == 8'($past(opa_r[7:0]) + $past(opb_r[7:0])) &&
        WB_DATA[31:24] == 8'($past(opa_r[31:24]) + $past(opb_r[31:24])) &&
        WB_INDEX == $past(cmd_r.rd))
        else $error("unsigned byte add lanes wrong");

    a_bad_reg_blocks: assert property (@(posedge CLK) disable iff (!NRST)
        exec && reg_bad |=> !WB_VALID && status_r.bad_reg && $stable(FLAGS_NZCV))
        else $error("reserved register name not refused");

    a_hx_bottom_lane: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_HALVING_ADD_SUB_EXCHANGE |=>
        WB_DATA[15:0] == 16'(({$past(opa_r[15]), $past(opa_r[15:0])} -
                              {$past(opb_r[31]), $past(opb_r[31:16])}) >> 1))
        else $error("halving exchange bottom lane wrong");

    a_sub_add_halved: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_HALVING_SUB_ADD_EXCHANGE |=>
        WB_DATA[31:16] == 16'(({$past(opa_r[31]), $past(opa_r[31:16])} -
                               {$past(opb_r[15]), $past(opb_r[15:0])}) >> 1) &&
        WB_DATA[15:0] == 16'(({$past(opa_r[15]), $past(opa_r[15:0])} +
                              {$past(opb_r[31]), $past(opb_r[31:16])}) >> 1))
        else $error("halving sub-add exchange lanes wrong");

    a_exchange_lanes: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_ADD_SUB_EXCHANGE |=>
        WB_DATA == {16'($past(opa_r[31:16]) + $past(opb_r[15:0])),
                    16'($past(opa_r[15:0]) - $past(opb_r[31:16]))})
        else $error("add-sub exchange lanes wrong");

    a_sub_byte_lanes: assert property (@(posedge CLK) disable iff (!NRST)
        exec && op_ok && cmd_r.op == simd_alu_pkg::OP_SIGNED_PACKED_SUB_BYTES |=>
        WB_DATA[15:8] == 8'($past(opa_r[15:8]) - $past(opb_r[15:8])) &&
        WB_DATA[23:16] == 8'($past(opa_r[23:16]) - $past(opb_r[23:16])))
        else $error("packed byte subtract lanes wrong");

endmodule

`default_nettype wire

// >>> tb/core_regfile_model.sv
// register-file side of the writeback port: counts and vets writebacks
// assumes: writebacks arrive on the ALU clock, one per WB_VALID pulse
`timescale 1ns/1ps
`default_nettype none
module core_regfile_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_valid,
    input wire logic [3:0] wb_index,
    output int unsigned writes,
    output int unsigned bad_writes
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            writes <= 0;
            bad_writes <= 0;
        end else if (wb_valid === 1'h1) begin
            writes <= writes + 1;
            // stack pointer and program counter must never be targets
            if (wb_index == simd_alu_pkg::REG_STACK || wb_index == simd_alu_pkg::REG_PC) begin
                bad_writes <= bad_writes + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/packed_simd_alu_bench.sv
// self-checking bench for packed_simd_alu over AXI4-Lite
// assumes: bench is the only master; BREADY and RREADY are held high
`timescale 1ns/1ps
`default_nettype none
module packed_simd_alu_bench;
    logic CLK = 1'h0, NRST = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, ARVALID = 1'h0;
    logic BREADY = 1'h1, RREADY = 1'h1;
    logic [5:0] AWADDR = 6'h00, ARADDR = 6'h00;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hF;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WB_VALID;
    logic [31:0] RDATA, WB_DATA, rd_word;
    logic [3:0] WB_INDEX, FLAGS_NZCV;
    logic [1:0] BRESP, RRESP, resp;
    int unsigned writes, bad_writes;
    int errors = 0;
    int checks = 0;

    packed_simd_alu dut_u (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .WB_VALID(WB_VALID), .WB_INDEX(WB_INDEX), .WB_DATA(WB_DATA), .FLAGS_NZCV(FLAGS_NZCV));
    core_regfile_model partner_u (.clk(CLK), .rst_n(NRST), .wb_valid(WB_VALID),
        .wb_index(WB_INDEX), .writes(writes), .bad_writes(bad_writes));

    always #2 CLK = ~CLK;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        while (!(aw && w)) begin
            @(posedge CLK);
            if (AWVALID && AWREADY === 1'h1) begin
                aw = 1'h1;
                AWVALID <= 1'h0;
            end
            if (WVALID && WREADY === 1'h1) begin
                w = 1'h1;
                WVALID <= 1'h0;
            end
        end
        do @(posedge CLK); while (BVALID !== 1'h1);
        r = BRESP;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        ARADDR <= a;
        ARVALID <= 1'h1;
        do @(posedge CLK); while (ARREADY !== 1'h1);
        ARVALID <= 1'h0;
        do @(posedge CLK); while (RVALID !== 1'h1);
        d = RDATA;
        r = RRESP;
    endtask

    function automatic logic [15:0] l16(logic [15:0] x, logic [15:0] y, logic s, logic h);
        logic [16:0] t;
        t = s ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
        return h ? t[16:1] : t[15:0];
    endfunction

    function automatic logic [7:0] l8(logic [7:0] x, logic [7:0] y, logic s, logic h);
        logic [8:0] t;
        t = s ? {x[7], x} - {y[7], y} : {x[7], x} + {y[7], y};
        return h ? t[8:1] : t[7:0];
    endfunction

    function automatic logic [31:0] model(logic [3:0] op, logic [31:0] a, logic [31:0] b);
        logic s, h;
        logic [31:0] r;
        s = op inside {4'h2, 4'h3, 4'h4, 4'h5};
        h = op inside {4'h2, 4'h3};
        for (int i = 0; i < 4; i++) r[8*i +: 8] = l8(a[8*i +: 8], b[8*i +: 8], s, h);
        case (op)
            4'h0: r = {l16(a[31:16], b[15:0], 1'h0, 1'h1), l16(a[15:0], b[31:16], 1'h1, 1'h1)};
            4'h1: r = {l16(a[31:16], b[15:0], 1'h1, 1'h1), l16(a[15:0], b[31:16], 1'h0, 1'h1)};
            4'h2, 4'h4, 4'hA: r = {l16(a[31:16], b[31:16], s, h), l16(a[15:0], b[15:0], s, h)};
            4'h6: r = {l16(a[31:16], b[15:0], 1'h0, 1'h0), l16(a[15:0], b[31:16], 1'h1, 1'h0)};
            4'h7: r = {l16(a[31:16], b[15:0], 1'h1, 1'h0), l16(a[15:0], b[31:16], 1'h0, 1'h0)};
            4'h8: r = a & b;
            4'h9: r = a ^ b;
            default: ;
        endcase
        return r;
    endfunction

    // rn=1, rm=2 keep clear of stack pointer and program counter
    task automatic run_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
            input logic [3:0] rd, input logic [1:0] cc, output logic [1:0] wb);
        wr(simd_alu_pkg::OFS_OPERAND_A, a, resp);
        wr(simd_alu_pkg::OFS_OPERAND_B, b, resp);
        wr(simd_alu_pkg::OFS_COMMAND, {12'h000, 4'h2, 4'h1, rd, 2'h0, cc, op}, resp);
        #1 wb[1] = WB_VALID;
        @(posedge CLK);
        #1 wb[0] = WB_VALID;
        @(posedge CLK);
    endtask

    task automatic reset_values();
        for (int i = 0; i < 6; i++) begin
            rd(6'(4 * i), rd_word, resp);
            chk(rd_word, 32'h0, "reset value");
            chk(32'(resp), 32'(simd_alu_pkg::RESP_OKAY), "read resp");
        end
        rd(6'h18, rd_word, resp);
        chk(32'(resp), 32'(simd_alu_pkg::RESP_SLVERR), "unmapped read");
        wr(6'h18, 32'hA5A5_5A5A, resp);
        chk(32'(resp), 32'(simd_alu_pkg::RESP_SLVERR), "unmapped write");
        chk(32'(FLAGS_NZCV), 32'h0, "reset flags");
    endtask

    task automatic packed_ops();
        logic [3:0] ops [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB};
        logic [31:0] av [2] = '{32'h7FFF_8000, 32'h80FF_017F};
        logic [31:0] bv [2] = '{32'h8001_7FFF, 32'h7F01_FF80};
        logic [1:0] wb;
        // all flags set so any packed op touching them shows
        wr(simd_alu_pkg::OFS_FLAGS, 32'hF000_0000, resp);
        foreach (av[j]) begin
            for (int i = 0; i < 10; i++) begin
                run_op(ops[i], av[j], bv[j], 4'(i), 2'h3, wb);
                chk(32'(wb), 32'h2, "writeback pulse");
                chk(32'(WB_INDEX), 32'(i), "writeback index");
                chk(WB_DATA, model(ops[i], av[j], bv[j]), "lane result");
                chk(32'(FLAGS_NZCV), 32'hF, "flags kept");
            end
        end
    endtask

    task automatic test_ops();
        logic [3:0] ops [4] = '{4'h8, 4'h9, 4'h8, 4'h9};
        logic [31:0] av [4] = '{32'hF0F0_0000, 32'h8000_0001, 32'hFFFF_FFFF, 32'h1234_5678};
        logic [31:0] bv [4] = '{32'h0F0F_FFFF, 32'h0000_0001, 32'h8000_0000, 32'h1234_5678};
        logic [1:0] cc [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        logic [3:0] fl [4] = '{4'h7, 4'h9, 4'hB, 4'h7};
        logic [1:0] wb;
        wr(simd_alu_pkg::OFS_FLAGS, 32'h3000_0000, resp);
        for (int i = 0; i < 4; i++) begin
            run_op(ops[i], av[i], bv[i], 4'h3, cc[i], wb);
            chk(32'(wb), 32'h0, "no writeback");
            chk(32'(FLAGS_NZCV), 32'(fl[i]), "test flags");
            rd(simd_alu_pkg::OFS_RESULT, rd_word, resp);
            chk(rd_word, model(ops[i], av[i], bv[i]), "test result");
        end
    endtask

    task automatic refused_ops();
        logic [1:0] wb;
        run_op(4'h6, 32'h1, 32'h1, simd_alu_pkg::REG_STACK, 2'h0, wb);
        chk(32'(wb), 32'h0, "refused writeback");
        rd(simd_alu_pkg::OFS_STATUS, rd_word, resp);
        chk(32'(rd_word[4:2]), 32'h4, "bad register status");
        run_op(4'hC, 32'h1, 32'h1, 4'h4, 2'h3, wb);
        chk(32'(wb), 32'h0, "unknown op writeback");
        rd(simd_alu_pkg::OFS_STATUS, rd_word, resp);
        chk(32'(rd_word[4:2]), 32'h2, "bad op status");
        chk(32'(FLAGS_NZCV), 32'h7, "refused flags");
    endtask

    initial begin
        repeat (2) @(posedge CLK);
        NRST <= 1'h1;
        @(posedge CLK);
        reset_values();
        packed_ops();
        test_ops();
        refused_ops();
        chk(writes, 32'h14, "writeback count");
        chk(bad_writes, 32'h0, "stack or pc written");
        wrap_up();
    end

    // whole run is under a thousand cycles; allow ten times that
    initial begin
        #40000;
        errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
